// File: hv_bt656_panel_output.sv
// Panel output stage: sync plus enable RGB timing and BT.656 byte stream
`timescale 1ns/1ps
`default_nettype none
`include "panel_out_params.svh"

module hv_bt656_panel_output
    import panel_out_pkg::*;
#(
    parameter int unsigned H_ACTIVE = `HV_H_ACTIVE_DEF,
    parameter int unsigned H_SYNC = `HV_H_SYNC_DEF,
    parameter int unsigned H_BACK = `HV_H_BACK_DEF,
    parameter int unsigned H_TOTAL = `HV_H_TOTAL_DEF,
    parameter int unsigned V_ACTIVE = `HV_V_ACTIVE_DEF,
    parameter int unsigned V_SYNC = `HV_V_SYNC_DEF,
    parameter int unsigned V_BACK = `HV_V_BACK_DEF,
    parameter int unsigned V_TOTAL = `HV_V_TOTAL_DEF,
    parameter int unsigned BT_ACTIVE = `BT_ACTIVE_DEF,
    parameter int unsigned BT_BLANK = `BT_BLANK_DEF,
    parameter int unsigned BT_FIELD = `BT_FIELD_DEF,
    parameter int unsigned BT_VBLANK = `BT_VBLANK_DEF
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic enable_in,
    input wire logic bt656_sel_in,
    input wire logic multi_channel_in,
    input wire logic [3:0] channel_id_in,
    input wire logic pix_valid_in,
    input wire logic [23:0] pix_data_in,
    output logic pix_ready_out,
    output logic dot_clock_out,
    output logic vsync_out,
    output logic hsync_out,
    output logic pixel_valid_window_out,
    output logic optional_valid_strobe_out,
    output logic [23:0] pixel_data_out
);
    // ----------------------------------------------------------------
    // Sized positions within line and frame
    // ----------------------------------------------------------------
    localparam int HW = `HCNT_W;
    localparam int VW = `VCNT_W;
    localparam logic [HW-1:0] HV_H_LAST = HW'(H_TOTAL - 1);
    localparam logic [HW-1:0] HV_H_SYNC = HW'(H_SYNC);
    localparam logic [HW-1:0] HV_H_DE = HW'(H_BACK);
    localparam logic [HW-1:0] HV_H_END = HW'(H_BACK + H_ACTIVE);
    localparam logic [VW-1:0] HV_V_LAST = VW'(V_TOTAL - 1);
    localparam logic [VW-1:0] HV_V_SYNC = VW'(V_SYNC);
    localparam logic [VW-1:0] HV_V_DE = VW'(V_BACK);
    localparam logic [VW-1:0] HV_V_END = VW'(V_BACK + V_ACTIVE);
    localparam logic [HW-1:0] BT_EAV_END = HW'(`CODE_LEN);
    localparam logic [HW-1:0] BT_SAV_AT = HW'(`CODE_LEN + BT_BLANK);
    localparam logic [HW-1:0] BT_ACT_AT = HW'(2 * `CODE_LEN + BT_BLANK);
    localparam logic [HW-1:0] BT_H_LAST = HW'(2 * `CODE_LEN + BT_BLANK + 2 * BT_ACTIVE - 1);
    localparam logic [VW-1:0] BT_FIELD_N = VW'(BT_FIELD);
    localparam logic [VW-1:0] BT_V_LAST = VW'(2 * BT_FIELD - 1);
    localparam logic [VW-1:0] BT_VBL = VW'(BT_VBLANK);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Visible window of the sync plus enable raster; used for ready and enable
    function automatic logic hv_window(input logic [HW-1:0] h, input logic [VW-1:0] v);
        hv_window = (h >= HV_H_DE) && (h < HV_H_END) && (v >= HV_V_DE) && (v < HV_V_END);
    endfunction

    out_state_t st;
    out_state_t next_st;
    logic field2;
    logic [VW-1:0] vline;
    logic vblank;
    logic in_eav;
    logic in_code;
    logic in_act;
    logic [HW-1:0] act_off;
    logic take;
    logic [7:0] code_byte;
    logic [7:0] bt_word;
    logic [HW-1:0] h_last;
    logic [VW-1:0] v_last;

    // ----------------------------------------------------------------
    // Byte stream position decode
    // ----------------------------------------------------------------
    // Fields follow each other in one line count; the second half is field 2
    always_comb begin
        field2 = st.vcnt >= BT_FIELD_N;
        vline = field2 ? st.vcnt - BT_FIELD_N : st.vcnt;
        vblank = vline < BT_VBL;
        in_eav = st.hcnt < BT_EAV_END;
        in_code = in_eav || ((st.hcnt >= BT_SAV_AT) && (st.hcnt < BT_ACT_AT));
        in_act = st.hcnt >= BT_ACT_AT;
        act_off = st.hcnt - BT_ACT_AT;
    end

    // Blanking is a multiple of four bytes, so the code index is the low bits
    timing_code_gen u_code (
        .idx_in(st.hcnt[1:0]),
        .field_in(field2),
        .vflag_in(vblank),
        .hflag_in(in_eav),
        .multi_channel_in(multi_channel_in),
        .channel_id_in(channel_id_in),
        .code_out(code_byte)
    );

    // ----------------------------------------------------------------
    // Color space converter word stream
    // ----------------------------------------------------------------
    // Upstream gives Y in [23:16], U in [15:8], V in [7:0]; one sample
    // is taken per byte pair, its chroma first and its luma held
    always_comb begin
        if (in_code) begin
            bt_word = code_byte;
        end else if (in_act && !vblank) begin
            case (act_off[1:0])
                2'h0: bt_word = take ? pix_data_in[15:8] : `BLANK_CHROMA;
                2'h2: bt_word = take ? pix_data_in[7:0] : `BLANK_CHROMA;
                default: bt_word = st.luma;
            endcase
        end else begin
            bt_word = st.hcnt[0] ? `BLANK_LUMA : `BLANK_CHROMA;
        end
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    // The sync, enable, data and counter registers update in the cycle where the dot clock falls, so the
    // panel sees half a dot period of setup before its rising edge
    always_comb begin
        next_st = st;
        take = st.ready && pix_valid_in;
        h_last = (st.mode == MODE_BT) ? BT_H_LAST : HV_H_LAST;
        v_last = (st.mode == MODE_BT) ? BT_V_LAST : HV_V_LAST;
        next_st.en = enable_in;
        next_st.dclk = st.en && enable_in && !st.dclk;
        next_st.ready = 1'b0;
        if (!st.en) begin
            // Mode is caught only while idle; a change mid-frame would tear
            next_st.mode = bt656_sel_in ? MODE_BT : MODE_HV;
            next_st.hcnt = '0;
            next_st.vcnt = '0;
            next_st.hsync = 1'b0;
            next_st.vsync = 1'b0;
            next_st.de = 1'b0;
            next_st.vld = 1'b0;
            next_st.data = '0;
            next_st.luma = `BLANK_LUMA;
        end else if (!st.dclk) begin
            // Ready stands in the cycle of the coming fall only
            case (st.mode)
                MODE_HV: next_st.ready = enable_in && hv_window(st.hcnt, st.vcnt);
                MODE_BT: next_st.ready = enable_in && in_act && !vblank && !act_off[0];
                default: next_st.ready = 1'b0;
            endcase
        end else begin
            case (st.mode)
                MODE_HV: begin
                    next_st.vsync = st.vcnt < HV_V_SYNC;
                    next_st.hsync = st.hcnt < HV_H_SYNC;
                    next_st.de = hv_window(st.hcnt, st.vcnt);
                    next_st.vld = 1'b0;
                    // An empty FIFO inside the window shows black, not stale data
                    next_st.data = take ? pix_data_in : 24'h000000;
                end
                MODE_BT: begin
                    next_st.vsync = 1'b0;
                    next_st.hsync = 1'b0;
                    next_st.de = 1'b0;
                    next_st.vld = in_act && !vblank;
                    next_st.data = {16'h0000, bt_word};
                    if (take) begin
                        next_st.luma = pix_data_in[23:16];
                    end else if (!in_act || vblank) begin
                        next_st.luma = `BLANK_LUMA;
                    end
                end
                default: begin
                    next_st.mode = MODE_HV;
                end
            endcase
            // Raster advance
            if (st.hcnt >= h_last) begin
                next_st.hcnt = '0;
                next_st.vcnt = (st.vcnt >= v_last) ? '0 : st.vcnt + VW'(1);
            end else begin
                next_st.hcnt = st.hcnt + HW'(1);
            end
        end
        if (!enable_in) begin
            next_st.ready = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st <= '{en: 1'b0, mode: MODE_HV, dclk: 1'b0, ready: 1'b0,
                    hcnt: '0, vcnt: '0, hsync: 1'b0, vsync: 1'b0,
                    de: 1'b0, vld: 1'b0, data: '0, luma: `BLANK_LUMA};
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // Pin mapping
    // ----------------------------------------------------------------
    // Words go to the pins as built; byte mode sits on the low lane
    assign dot_clock_out = st.dclk;
    assign pix_ready_out = st.ready;
    assign vsync_out = st.vsync;
    assign hsync_out = st.hsync;
    assign pixel_valid_window_out = st.de;
    assign optional_valid_strobe_out = st.vld;
    assign pixel_data_out = st.data;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);

    logic bt_mode;
    assign bt_mode = st.mode == MODE_BT;

    sequence s_lead;
        pixel_data_out[7:0] == `CODE_LEAD ##2 pixel_data_out[7:0] == `CODE_ZERO
            ##2 pixel_data_out[7:0] == `CODE_ZERO;
    endsequence

    sequence s_blank_pair;
        pixel_data_out[7:0] == `BLANK_CHROMA ##2 pixel_data_out[7:0] == `BLANK_LUMA;
    endsequence

    a_vsync_frame_start: assert property (
        $rose(vsync_out) |-> st.vcnt == '0 && st.hcnt == HW'(1) && !bt_mode)
        else $error("vertical sync began away from frame start");

    a_hsync_line_start: assert property (
        $rose(hsync_out) |-> st.hcnt == HW'(1) && $fell(dot_clock_out))
        else $error("horizontal sync began away from line start");

    a_data_on_fall: assert property (
        st.en && ($changed(pixel_data_out) || $changed(pixel_valid_window_out))
            |-> $fell(dot_clock_out))
        else $error("outputs moved without a dot clock fall");

    a_rgb_pixel_taken: assert property (
        st.ready && pix_valid_in && !bt_mode
            |=> pixel_valid_window_out && pixel_data_out == $past(pix_data_in))
        else $error("taken RGB pixel not presented with enable");

    a_bt_no_syncs: assert property (
        bt_mode && st.en |-> !hsync_out && !vsync_out && !pixel_valid_window_out)
        else $error("sync wire active in byte stream mode");

    a_bt_byte_lane: assert property (
        bt_mode |-> pixel_data_out[23:8] == 16'h0000)
        else $error("upper lanes driven in byte stream mode");

    a_code_preamble: assert property (
        bt_mode && st.en && $fell(dot_clock_out) && st.hcnt == HW'(1)
            |-> s_lead ##2 pixel_data_out[7] && pixel_data_out[4])
        else $error("end code lead bytes or H flag wrong");

    a_blank_fill: assert property (
        bt_mode && st.en && $fell(dot_clock_out) && st.hcnt == BT_EAV_END + HW'(1)
            |-> s_blank_pair)
        else $error("blanking does not start with 80H then 10H");

    a_format_parity: assert property (
        bt_mode && $fell(dot_clock_out) && !$past(multi_channel_in)
            && (st.hcnt == BT_EAV_END || st.hcnt == BT_ACT_AT)
            |-> pixel_data_out[3:0] == {pixel_data_out[5] ^ pixel_data_out[4],
                pixel_data_out[6] ^ pixel_data_out[4],
                pixel_data_out[6] ^ pixel_data_out[5],
                ^pixel_data_out[6:4]})
        else $error("format byte protection bits wrong");

    a_sav_hflag: assert property (
        bt_mode && $fell(dot_clock_out) && st.hcnt == BT_ACT_AT
            |-> pixel_data_out[7] && !pixel_data_out[4])
        else $error("start code H flag not zero");

    a_multi_channel: assert property (
        bt_mode && $fell(dot_clock_out) && $past(multi_channel_in)
            && (st.hcnt == BT_EAV_END || st.hcnt == BT_ACT_AT)
            |-> pixel_data_out[3:0] == $past(channel_id_in))
        else $error("channel identifier missing from format byte");

    a_uyvy_order: assert property (
        bt_mode && st.ready && pix_valid_in && act_off[1:0] == 2'h0
            |=> pixel_data_out[7:0] == $past(pix_data_in[15:8])
            ##2 pixel_data_out[7:0] == $past(pix_data_in[23:16], 3))
        else $error("active samples not in U, Y order");

    a_valid_strobe: assert property (
        bt_mode && $fell(dot_clock_out) |-> optional_valid_strobe_out
            == ($past(in_act) && !$past(vblank)))
        else $error("valid strobe outside active bytes");

    // Once idle has settled the panel sees no dot clock, no data and no enables
    a_idle_quiet: assert property (
        !st.en && !$past(st.en) |-> !dot_clock_out && pixel_data_out == 24'h000000
            && !pixel_valid_window_out && !optional_valid_strobe_out)
        else $error("outputs not quiet while idle");

    // Field and blanking flags of both format bytes, judged from the line count
    a_field_flags: assert property (
        bt_mode && $fell(dot_clock_out) && (st.hcnt == BT_EAV_END || st.hcnt == BT_ACT_AT)
            |-> pixel_data_out[6] == (st.vcnt >= BT_FIELD_N)
            && pixel_data_out[5] == (st.vcnt < BT_VBL
                || (st.vcnt >= BT_FIELD_N && st.vcnt < BT_FIELD_N + BT_VBL)))
        else $error("field or blanking flag wrong in format byte");

    // The start code follows the blanking words with H cleared
    a_sav_preamble: assert property (
        bt_mode && st.en && $fell(dot_clock_out) && st.hcnt == BT_SAV_AT + HW'(1)
            |-> s_lead ##2 pixel_data_out[7] && !pixel_data_out[4])
        else $error("start code does not follow the blanking words");

    // At most one sample is wanted per dot
    a_ready_single: assert property (
        pix_ready_out |=> !pix_ready_out)
        else $error("sample requested twice in one dot");
endmodule
`default_nettype wire

// File: panel_out_params.svh
// Default timing figures and fixed codes of the panel output stage
`ifndef PANEL_OUT_PARAMS_SVH
`define PANEL_OUT_PARAMS_SVH

// ----------------------------------------------------------------
// Counter widths
// ----------------------------------------------------------------
`define HCNT_W 12
`define VCNT_W 11

// ----------------------------------------------------------------
// Sync plus enable timing, in dot clocks and lines
// ----------------------------------------------------------------
`define HV_H_ACTIVE_DEF 32
`define HV_H_SYNC_DEF 4
`define HV_H_BACK_DEF 8
`define HV_H_TOTAL_DEF 48
`define HV_V_ACTIVE_DEF 8
`define HV_V_SYNC_DEF 2
`define HV_V_BACK_DEF 3
`define HV_V_TOTAL_DEF 13

// ----------------------------------------------------------------
// Byte stream timing, in bytes (active in two-byte samples) and lines
// ----------------------------------------------------------------
`define BT_ACTIVE_DEF 16
`define BT_BLANK_DEF 8
`define BT_FIELD_DEF 6
`define BT_VBLANK_DEF 2

// ----------------------------------------------------------------
// Fixed words of the byte stream
// ----------------------------------------------------------------
`define CODE_LEAD 8'hFF
`define CODE_ZERO 8'h00
`define BLANK_CHROMA 8'h80
`define BLANK_LUMA 8'h10
`define CODE_LEN 4

`endif

// File: panel_out_pkg.sv
// Types shared by the panel output stage
`default_nettype none
`include "panel_out_params.svh"
package panel_out_pkg;
    typedef enum logic [1:0] {
        MODE_HV = 2'b01,
        MODE_BT = 2'b10
    } out_mode_t;

    typedef struct packed {
        logic en;
        out_mode_t mode;
        logic dclk;
        logic ready;
        logic [`HCNT_W-1:0] hcnt;
        logic [`VCNT_W-1:0] vcnt;
        logic hsync;
        logic vsync;
        logic de;
        logic vld;
        logic [23:0] data;
        logic [7:0] luma;
    } out_state_t;
endpackage
`default_nettype wire

// File: timing_code_gen.sv
// Builder of one byte of an embedded timing reference code
`timescale 1ns/1ps
`default_nettype none
`include "panel_out_params.svh"
module timing_code_gen (
    input wire logic [1:0] idx_in,
    input wire logic field_in,
    input wire logic vflag_in,
    input wire logic hflag_in,
    input wire logic multi_channel_in,
    input wire logic [3:0] channel_id_in,
    output logic [7:0] code_out
);
    logic [3:0] prot;

    // ----------------------------------------------------------------
    // Protection nibble and code bytes
    // ----------------------------------------------------------------
    // Parity lets a receiver fix single bit errors in the flags
    always_comb begin
        prot = {vflag_in ^ hflag_in, field_in ^ hflag_in,
                field_in ^ vflag_in, field_in ^ vflag_in ^ hflag_in};
        if (multi_channel_in) begin
            prot = channel_id_in;
        end
    end

    // Three fixed lead bytes, then the format byte
    always_comb begin
        case (idx_in)
            2'h0: code_out = `CODE_LEAD;
            2'h1: code_out = `CODE_ZERO;
            2'h2: code_out = `CODE_ZERO;
            default: code_out = {1'b1, field_in, vflag_in, hflag_in, prot};
        endcase
    end
endmodule
`default_nettype wire

// File: panel_sink.sv
// Panel or byte-stream receiver model that records the first 2048 dots it samples
`timescale 1ns/1ps
`default_nettype none
module panel_sink (
    input wire logic run_in,
    input wire logic dot_clock_in,
    input wire logic vsync_in,
    input wire logic hsync_in,
    input wire logic window_in,
    input wire logic strobe_in,
    input wire logic [23:0] data_in
);
    // ----------------------------------------------------------------
    // Capture memory
    // ----------------------------------------------------------------
    logic [27:0] cap [0:2047];
    int n = -1;

    // Sample on the rising dot clock; the first rise comes before dot 0, so it is skipped
    // Outputs only move when the dot clock falls, so no race at the rising edge
    always @(posedge dot_clock_in or negedge run_in) begin
        if (!run_in) begin
            n <= -1;
        end else begin
            if (n >= 0 && n < 2048) begin
                cap[n] <= {vsync_in, hsync_in, window_in, strobe_in, data_in};
            end
            n <= n + 1;
        end
    end
endmodule
`default_nettype wire

// File: test_hv_bt656_panel_output.sv
// Self-checking bench of the panel output stage in both output modes
`timescale 1ns/1ps
`default_nettype none
`include "panel_out_params.svh"
module test_hv_bt656_panel_output;
    import panel_out_pkg::*;
    // ----------------------------------------------------------------
    // Timing figures, taken from the defaults the design is built with
    // ----------------------------------------------------------------
    localparam int HT = `HV_H_TOTAL_DEF;
    localparam int VT = `HV_V_TOTAL_DEF;
    localparam int HS = `HV_H_SYNC_DEF;
    localparam int VS = `HV_V_SYNC_DEF;
    localparam int HB = `HV_H_BACK_DEF;
    localparam int HA = `HV_H_ACTIVE_DEF;
    localparam int VB = `HV_V_BACK_DEF;
    localparam int VA = `HV_V_ACTIVE_DEF;
    localparam int BL = `BT_BLANK_DEF;
    localparam int BF = `BT_FIELD_DEF;
    localparam int BV = `BT_VBLANK_DEF;
    localparam int LN = 2 * `CODE_LEN + BL + 2 * `BT_ACTIVE_DEF;

    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic enable_in = 1'b0;
    logic bt656_sel_in = 1'b0;
    logic multi_channel_in = 1'b0;
    logic [3:0] channel_id_in = 4'h0;
    logic pix_valid_in = 1'b0;
    logic [23:0] pix_data_in = 24'h000000;
    logic pix_ready_out, dot_clock_out, vsync_out, hsync_out;
    logic pixel_valid_window_out, optional_valid_strobe_out;
    logic [23:0] pixel_data_out;
    logic feed_on = 1'b0;
    logic [7:0] sn = 8'h01;
    logic [23:0] taken [$];
    int n_errors = 0;
    int n_checks = 0;
    int cycles = 0;

    hv_bt656_panel_output dut (
        .clk_in(clk_in), .rstn_in(rstn_in), .enable_in(enable_in),
        .bt656_sel_in(bt656_sel_in), .multi_channel_in(multi_channel_in),
        .channel_id_in(channel_id_in), .pix_valid_in(pix_valid_in),
        .pix_data_in(pix_data_in), .pix_ready_out(pix_ready_out),
        .dot_clock_out(dot_clock_out), .vsync_out(vsync_out), .hsync_out(hsync_out),
        .pixel_valid_window_out(pixel_valid_window_out),
        .optional_valid_strobe_out(optional_valid_strobe_out),
        .pixel_data_out(pixel_data_out)
    );

    panel_sink sink (
        .run_in(enable_in), .dot_clock_in(dot_clock_out), .vsync_in(vsync_out),
        .hsync_in(hsync_out), .window_in(pixel_valid_window_out),
        .strobe_in(optional_valid_strobe_out), .data_in(pixel_data_out)
    );

    // ----------------------------------------------------------------
    // Clock, upstream sample source and hang guard
    // ----------------------------------------------------------------
    initial begin
        forever #12.5 clk_in = ~clk_in;
    end

    // Each taken sample is logged in order; codes FF and 00 never appear in the pattern within one byte-stream frame
    always @(posedge clk_in) begin
        pix_valid_in <= feed_on;
        if (pix_ready_out === 1'b1 && pix_valid_in === 1'b1) begin
            taken.push_back(pix_data_in);
            pix_data_in <= {8'h40 + sn, 8'h10 + sn, 8'h50 + sn};
            sn <= sn + 8'h01;
        end
    end

    // Four frames of about 1150 to 1300 cycles each; under half the ceiling
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 10000) begin
            n_errors = n_errors + 1;
            final_report();
        end
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Mode is only caught while idle, so drop the run request first
    task automatic start(input logic bt, input logic feed, input int dots);
        int k;
        enable_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        bt656_sel_in <= bt;
        feed_on <= feed;
        taken.delete();
        sn <= 8'h01;
        pix_data_in <= 24'h401050;
        @(posedge clk_in);
        enable_in <= 1'b1;
        k = 0;
        // Run a few dots past the frame, so stopping never cuts a code or blank pair
        while (sink.n < dots + 8 && k < 4000) begin
            @(posedge clk_in);
            k++;
        end
    endtask

    function automatic logic [7:0] xy(input logic f, input logic v, input logic h,
                                      input logic multi);
        return {1'b1, f, v, h, multi ? 4'h5 : {v ^ h, f ^ h, f ^ v, f ^ v ^ h}};
    endfunction

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic rgb_frame(input logic feed);
        int l, d, de_n;
        logic [27:0] c;
        start(1'b0, feed, HT * VT);
        de_n = 0;
        for (l = 0; l < VT; l++) begin
            for (d = 0; d < HT; d++) begin
                c = sink.cap[l * HT + d];
                check("hsync", {31'h0, c[26]}, {31'h0, d < HS});
                check("vsync", {31'h0, c[27]}, {31'h0, l < VS});
                check("window", {31'h0, c[25]},
                      {31'h0, l >= VB && l < VB + VA && d >= HB && d < HB + HA});
                if (c[25] === 1'b1) begin
                    check("pixel", {8'h0, c[23:0]}, feed ? {8'h0, taken[de_n]} : 32'h0);
                    de_n++;
                end
            end
        end
        check("pixels per frame", de_n, HA * VA);
    endtask

    // Whole interlaced frame compared byte by byte, strobe and sync wires included
    task automatic bt_frame(input logic multi);
        int l, b, a, i;
        logic f, v, act;
        logic [7:0] e;
        logic [23:0] s;
        multi_channel_in <= multi;
        channel_id_in <= 4'h5;
        start(1'b1, 1'b1, 2 * BF * LN);
        a = 0;
        for (l = 0; l < 2 * BF; l++) begin
            f = l >= BF;
            v = (l % BF) < BV;
            for (b = 0; b < LN; b++) begin
                act = 1'b0;
                i = (b < 4) ? b : b - 4 - BL;
                if (b < 4 || (b >= 4 + BL && b < 8 + BL)) begin
                    e = (i == 0) ? 8'hFF : (i < 3) ? 8'h00 : xy(f, v, b < 4, multi);
                end else if (b < 8 + BL || v) begin
                    e = (b % 2 == 1) ? 8'h10 : 8'h80;
                end else begin
                    s = taken[a / 2];
                    e = (a % 2 == 1) ? s[23:16] : ((a / 2) % 2 == 1) ? s[7:0] : s[15:8];
                    act = 1'b1;
                    a++;
                end
                check("stream byte", {4'h0, sink.cap[l * LN + b]},
                      {7'h0, act, 16'h0, e});
            end
        end
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk_in);
        check("outputs in reset", {2'b00, pix_ready_out, dot_clock_out, vsync_out, hsync_out,
              pixel_valid_window_out, optional_valid_strobe_out, pixel_data_out}, 32'h0);
        rstn_in <= 1'b1;
        @(posedge clk_in);
        rgb_frame(1'b1);
        rgb_frame(1'b0);
        bt_frame(1'b0);
        bt_frame(1'b1);
        final_report();
    end
endmodule
`default_nettype wire
